/* File: dsc_drive_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module dsc_drive_ctrl
   import dsc_pkg::*;
#(
   parameter int unsigned MOTOR_WAIT_CYC = MOTOR_WAIT_CYC_DEF,
   parameter int unsigned CHUCK_CYC = CHUCK_CYC_DEF,
   parameter int unsigned HOME_STEP_CYC = HOME_STEP_CYC_DEF,
   parameter int unsigned SETTLE_CYC = SETTLE_CYC_DEF
) (
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // pins from host, mechanism and straps
   input wire dsc_host_s host_in,
   input wire dsc_mech_s mech_in,
   input wire dsc_strap_s strap_in,
   // drive outputs
   output logic spindle_run,
   output logic lamp_on,
   output logic shared_line_out,
   output logic shared_line_oe,
   output logic head_step,
   output logic head_step_inward,
   output logic ready,
   output logic media_swapped_flag,
   output logic standby
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [IN_W-1:0] s1; // first sync stage, read by s2 only
      logic [IN_W-1:0] s2;
      logic [IN_W-1:0] s3;
      logic [IN_W-1:0] flt; // accepted pin levels
      logic step_prev;
      logic disk_prev;
      logic idx_prev;
      logic [2:0] boot_cnt;
      dsc_hm_e hm;
      logic [STEP_W-1:0] hm_steps;
      logic [CNT_W-1:0] hm_cnt;
      logic [CNT_W-1:0] settle_cnt;
      logic [CNT_W-1:0] chuck_cnt;
      logic chucking;
      logic chuck_done;
      logic [CNT_W-1:0] spin_cnt;
      logic spin_done;
      logic [1:0] idx_cnt;
      logic media;
      logic rehome;
      logic head_step;
      logic head_dir;
      logic spindle;
      logic lamp;
      logic ready;
      logic sh_out;
      logic sh_oe;
      logic standby;
      logic ph_wr; // write data phase pending
      logic [REG_AW-1:0] ph_addr;
      logic [31:0] hrdata;
   } dsc_state_s;

   dsc_state_s q; // registered state
   dsc_state_s n; // next state
   dsc_host_s hf; // filtered host pins
   dsc_mech_s mf; // filtered mechanism pins
   dsc_strap_s sf; // filtered straps
   logic selected;
   logic step_ok;
   logic disk_rise;
   logic disk_fall;
   logic idx_rise;
   logic host_run;
   logic run;
   logic addr_ok;
   logic [IN_W-1:0] diff;

   // decode of the one-hot address strap against select lines
   function automatic logic unit_match(input logic [3:0] sel,
                                       input logic [3:0] adr);
      unit_match = |(sel & adr);
   endfunction

   // register read mux
   function automatic logic [31:0] rd_word(input logic [REG_AW-1:0] a,
                                           input dsc_state_s s,
                                           input logic sel_now);
      logic [31:0] w;
      w = RD_ZERO;
      case (a)
         STATUS_OFS: begin
            w[9:0] = {s.chucking, s.rehome, s.ready, s.media,
                      s.standby, (s.hm != HM_IDLE), s.spindle,
                      s.flt[HOST_W+MECH_W-1], sel_now, s.lamp};
         end
         STRAPS_OFS: begin
            w[STRAP_W-1:0] = s.flt[IN_W-1:HOST_W+MECH_W];
         end
         default: begin
            w = RD_ZERO; // control reads zero, holes read zero
         end
      endcase
      rd_word = w;
   endfunction

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      n = q;
      // pins pass three stages; a change counts once s2 and s3 agree
      n.s1 = {strap_in, mech_in, host_in};
      n.s2 = q.s1;
      n.s3 = q.s2;
      diff = q.s2 ^ q.s3;
      n.flt = (~diff & q.s3) | (diff & q.flt);
      hf = dsc_host_s'(q.flt[HOST_W-1:0]);
      mf = dsc_mech_s'(q.flt[HOST_W+MECH_W-1:HOST_W]);
      sf = dsc_strap_s'(q.flt[IN_W-1:HOST_W+MECH_W]);

      // edges of filtered levels
      selected = unit_match(hf.unit_select, sf.unit_address_straps);
      n.step_prev = hf.track_advance_pulse;
      n.disk_prev = mf.disk_present;
      n.idx_prev = mf.index_sense;
      disk_rise = mf.disk_present & ~q.disk_prev;
      disk_fall = ~mf.disk_present & q.disk_prev;
      idx_rise = mf.index_sense & ~q.idx_prev;
      // host steps are dropped while homing runs
      step_ok = hf.track_advance_pulse & ~q.step_prev &
                (q.hm == HM_IDLE);

      // hub seating spin after insertion
      if (!mf.disk_present) begin
         n.chucking = 1'b0;
         n.chuck_done = 1'b0;
         n.chuck_cnt = '0;
      end else if (disk_rise) begin
         n.chucking = 1'b1;
         n.chuck_cnt = '0;
      end else if (q.chucking) begin
         if (q.chuck_cnt >= CNT_W'(CHUCK_CYC - 1)) begin
            n.chucking = 1'b0;
            n.chuck_done = 1'b1;
         end else begin
            n.chuck_cnt = q.chuck_cnt + 1'b1;
         end
      end

      // host spindle condition, chosen by the motor strap
      if (sf.motor_follows_select_strap) begin
         host_run = mf.disk_present &
                    (hf.spindle_request | selected);
      end else begin
         host_run = mf.disk_present & hf.spindle_request;
      end
      // no disk gates everything, seating included
      run = mf.disk_present & (host_run | q.chucking);
      n.spindle = run;

      // motor-on wait timer, restarts whenever the request drops
      if (!host_run) begin
         n.spin_cnt = '0;
         n.spin_done = 1'b0;
      end else if (!q.spin_done) begin
         if (q.spin_cnt >= CNT_W'(MOTOR_WAIT_CYC - 1)) begin
            n.spin_done = 1'b1;
         end else begin
            n.spin_cnt = q.spin_cnt + 1'b1;
         end
      end

      // index pulses counted only at speed
      if (!q.spindle || !mf.speed_ok) begin
         n.idx_cnt = '0;
      end else if (idx_rise && q.idx_cnt != IDX_NEED) begin
         n.idx_cnt = q.idx_cnt + 1'b1;
      end

      // ready drops the cycle after the request goes away
      n.ready = mf.disk_present & q.chuck_done & host_run &
                q.spin_done & mf.speed_ok & (q.idx_cnt == IDX_NEED) &
                (q.hm == HM_IDLE);

      // seek and homing; motor state plays no part here
      n.head_step = 1'b0;
      if (q.settle_cnt != '0) begin
         n.settle_cnt = q.settle_cnt - 1'b1;
      end
      case (q.hm)
         HM_BOOT: begin
            // wait until the strap synchroniser has settled
            n.boot_cnt = q.boot_cnt + 1'b1;
            n.hm_steps = '0;
            if (q.boot_cnt == BOOT_CYC) begin
               n.hm = sf.auto_home_strap ? HM_STEP : HM_IDLE;
            end
         end
         HM_IDLE: begin
            n.hm_steps = '0;
            if (q.rehome) begin
               n.rehome = 1'b0;
               n.hm = HM_STEP;
            end else if (step_ok) begin
               n.head_step = 1'b1;
               n.head_dir = hf.step_toward_center;
               n.settle_cnt = CNT_W'(SETTLE_CYC);
            end
         end
         HM_STEP: begin
            if (mf.track0_sense || q.hm_steps == STEP_W'(HOME_STEPS)) begin
               n.hm = HM_IDLE;
            end else begin
               n.head_step = 1'b1;
               n.head_dir = 1'b0; // outward
               n.hm_steps = q.hm_steps + 1'b1;
               n.hm_cnt = '0;
               n.settle_cnt = CNT_W'(SETTLE_CYC);
               n.hm = HM_WAIT;
            end
         end
         HM_WAIT: begin
            // wait plus the step cycle make one step period, so the
            // worst case of all steps stays inside the bound
            if (q.hm_cnt >= CNT_W'(HOME_STEP_CYC - 2)) begin
               n.hm = HM_STEP;
            end else begin
               n.hm_cnt = q.hm_cnt + 1'b1;
            end
         end
         default: begin
            n.hm = HM_IDLE;
         end
      endcase

      // change flag: cleared by a selected step, set wins
      if (mf.disk_present && step_ok && selected) begin
         n.media = 1'b0;
      end
      if (disk_fall) begin
         n.media = 1'b1;
      end

      // stand-by only gates power, never a command path
      n.standby = ~q.spindle & (q.settle_cnt == '0) &
                  (q.hm == HM_IDLE);

      // front lamp
      case ({sf.lamp_mode_bit1, sf.lamp_mode_bit0})
         2'b00: n.lamp = selected | hf.host_busy_lamp_in;
         2'b01: n.lamp = hf.host_busy_lamp_in;
         2'b10: n.lamp = run | hf.host_busy_lamp_in | q.chucking;
         2'b11: n.lamp = (selected & q.ready) | hf.host_busy_lamp_in;
         default: n.lamp = 1'b0;
      endcase

      // shared line; change strap wins should both be fitted
      if (sf.pin_out_change_strap) begin
         n.sh_oe = 1'b1;
         n.sh_out = q.media;
      end else if (sf.ready_out_strap) begin
         n.sh_oe = 1'b1;
         n.sh_out = q.ready;
      end else begin
         n.sh_oe = 1'b0;
         n.sh_out = 1'b0;
      end

      // ahb-lite: zero wait, read data latched at address phase
      addr_ok = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
      if (hready) begin
         n.ph_wr = addr_ok & hwrite;
         n.ph_addr = haddr[REG_AW-1:0];
         n.hrdata = (addr_ok & ~hwrite) ?
                    rd_word(haddr[REG_AW-1:0], q, selected) : RD_ZERO;
      end
      // a write wins over the idle-state clear of the same cycle
      if (q.ph_wr && q.ph_addr == CTRL_OFS && hwdata[CTRL_REHOME_BIT]) begin
         n.rehome = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.s1 <= {STRAP_SHIPPED, {(HOST_W + MECH_W){1'b0}}};
         q.s2 <= {STRAP_SHIPPED, {(HOST_W + MECH_W){1'b0}}};
         q.s3 <= {STRAP_SHIPPED, {(HOST_W + MECH_W){1'b0}}};
         q.flt <= {STRAP_SHIPPED, {(HOST_W + MECH_W){1'b0}}};
         q.hm <= HM_BOOT;
         q.media <= 1'b1; // flag set at power on
      end else begin
         q <= n;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.hrdata;
   assign spindle_run = q.spindle;
   assign lamp_on = q.lamp;
   assign shared_line_out = q.sh_out;
   assign shared_line_oe = q.sh_oe;
   assign head_step = q.head_step;
   assign head_step_inward = q.head_dir;
   assign ready = q.ready;
   assign media_swapped_flag = q.media;
   assign standby = q.standby;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_host_step;
      hf.track_advance_pulse && !q.step_prev;
   endsequence

   a_no_disk_spin: assert property (!mf.disk_present |=> !spindle_run)
      else $error("spindle runs with no disk");
   a_select_motor: assert property (
      (sf.motor_follows_select_strap && mf.disk_present && selected)
      |=> spindle_run)
      else $error("select did not start spindle");
   a_ready_causes: assert property (
      ready |-> q.chuck_done && q.spin_done && q.idx_cnt == IDX_NEED)
      else $error("ready without its conditions");
   a_home_not_ready: assert property ((q.hm != HM_IDLE) |=> !ready)
      else $error("ready while homing");
   a_seek_any_motor: assert property (
      (s_host_step and q.hm == HM_IDLE && !q.rehome) |=> head_step)
      else $error("host step not passed to head");
   a_home_blocks_step: assert property (
      (s_host_step and q.hm == HM_WAIT) |=> head_step_inward == 1'b0)
      else $error("host step acted during homing");
   a_home_step_bound: assert property (
      (q.hm != HM_IDLE) |-> q.hm_steps <= STEP_W'(HOME_STEPS))
      else $error("homing exceeded step bound");
   a_standby_entry: assert property (
      (!q.spindle && q.settle_cnt == '0 && q.hm == HM_IDLE) |=> standby)
      else $error("stand-by not entered");
   a_shared_undriven: assert property (
      (!sf.pin_out_change_strap && !sf.ready_out_strap) |=> !shared_line_oe)
      else $error("shared line driven with straps off");
   a_shared_change: assert property (
      sf.pin_out_change_strap |=>
      shared_line_oe && shared_line_out == $past(q.media))
      else $error("shared line not carrying change flag");
   a_media_removal: assert property (
      (q.disk_prev && !mf.disk_present) |=> media_swapped_flag)
      else $error("change flag not set on removal");
   a_lamp_busy_only: assert property (
      (sf.lamp_mode_bit0 && !sf.lamp_mode_bit1) |=>
      lamp_on == $past(hf.host_busy_lamp_in))
      else $error("lamp mode 1 wrong");

endmodule
`default_nettype wire

/* File: dsc_pkg.sv */
// What this block does
// - seeking works whether spindle turns or not
// - stand-by when motor stopped and seek settled
// - stand-by never delays any host command
// - selected only by matching address strap line
// - motor-select strap off: request and disk
// - motor-select strap on: request or select
// - never spin without a disk installed
// - spin on insertion to seat hub
// - shared line carries change flag or ready
// - both output straps off: line undriven
// - auto-home strap off: no power-on homing
// - auto-home on: reach outer track in bound
// - homing holds not-ready, ignores step pulses
// - lamp mode 0: select or busy input
// - lamp mode 1: busy input only
// - lamp mode 2: spin, busy, or seating
// - lamp mode 3: selected and ready, or busy
// - shipped straps: unit 1, change, frame ground
// - ready after seating, wait, speed, two indexes
// - change flag set on power/removal, step clears
package dsc_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_KHZ = 50000; // 50 MHz clock
   localparam int unsigned MOTOR_WAIT_MS = 400; // request to ready
   localparam int unsigned CHUCK_MS = 750; // hub seating spin
   localparam int unsigned HOME_BOUND_MS = 255; // whole homing bound
   localparam int unsigned HOME_STEPS = 85; // worst-case step count
   localparam int unsigned SETTLE_MS = 18; // head settle after step
   localparam int unsigned MOTOR_WAIT_CYC_DEF = MOTOR_WAIT_MS * CLK_KHZ;
   localparam int unsigned CHUCK_CYC_DEF = CHUCK_MS * CLK_KHZ;
   // longest time per step, so rounded down by the division
   localparam int unsigned HOME_STEP_CYC_DEF =
      HOME_BOUND_MS * CLK_KHZ / HOME_STEPS;
   localparam int unsigned SETTLE_CYC_DEF = SETTLE_MS * CLK_KHZ;
   localparam int CNT_W = 26; // wide enough for the longest count
   localparam int STEP_W = 7; // homing step counter
   localparam logic [2:0] BOOT_CYC = 3'h7; // strap sync settle time
   localparam logic [1:0] IDX_NEED = 2'h2; // index pulses for ready

   // ---------------------------------------------------------------
   // pin groups
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0] unit_select; // one line per address
      logic spindle_request; // host motor-on
      logic host_busy_lamp_in; // host in-use
      logic track_advance_pulse; // host step
      logic step_toward_center; // host direction
   } dsc_host_s;

   typedef struct packed {
      logic disk_present; // disk sensor
      logic index_sense; // index hole sensor
      logic speed_ok; // spindle above 80% of rated speed
      logic track0_sense; // head on outermost track
   } dsc_mech_s;

   typedef struct packed {
      logic [3:0] unit_address_straps; // one-hot unit address
      logic motor_follows_select_strap;
      logic pin_out_change_strap;
      logic ready_out_strap;
      logic auto_home_strap;
      logic lamp_mode_bit0;
      logic lamp_mode_bit1;
      logic frame_ground_strap;
   } dsc_strap_s;

   localparam int HOST_W = $bits(dsc_host_s);
   localparam int MECH_W = $bits(dsc_mech_s);
   localparam int STRAP_W = $bits(dsc_strap_s);
   localparam int IN_W = HOST_W + MECH_W + STRAP_W;
   // unit 1, change output and frame ground fitted
   localparam logic [10:0] STRAP_SHIPPED = 11'h121;

   // homing sequencer
   typedef enum logic [1:0] {
      HM_BOOT = 2'b00,
      HM_IDLE = 2'b01,
      HM_STEP = 2'b10,
      HM_WAIT = 2'b11
   } dsc_hm_e;

   // ---------------------------------------------------------------
   // register map (byte offsets, 32-bit words)
   // ---------------------------------------------------------------
   localparam int REG_AW = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00; // write bit0: re-home
   localparam logic [7:0] STATUS_OFS = 8'h04; // live drive state
   localparam logic [7:0] STRAPS_OFS = 8'h08; // filtered straps
   localparam int CTRL_REHOME_BIT = 0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage

/* File: dsc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------
// host controller on the shared cable
// -----------------------------------------------------------------
module dsc_host_model
   import dsc_pkg::*;
(
   input wire logic hclk,
   input wire logic [1:0] unit_idx, // which select line to drive
   input wire logic sel_en, // drive a select line at all
   input wire logic motor_on, // motor-on request level
   input wire logic in_use, // lamp in-use level
   input wire logic step_go, // one-cycle request for a step pulse
   input wire logic step_in, // direction: 1 toward centre
   output var dsc_host_s host_out
);
   logic [3:0] ph = 4'h0; // step pulse phase, 0 = idle

   // pulse is 6 cycles high, then at least 9 low before the next one,
   // so the drive's edge detector never sees two steps merge
   always @(posedge hclk) begin
      if (ph != 4'h0) begin
         ph <= ph + 4'h1;
      end else if (step_go) begin
         ph <= 4'h1;
      end
   end

   // only one select line at a time, one address per drive
   always_comb begin
      host_out.unit_select = sel_en ? (4'h1 << unit_idx) : 4'h0;
      host_out.spindle_request = motor_on;
      host_out.host_busy_lamp_in = in_use;
      host_out.track_advance_pulse = (ph != 4'h0) && (ph < 4'h7);
      host_out.step_toward_center = step_in; // copied from step_in each cycle, not held by the model
   end
endmodule
`default_nettype wire

/* File: dsc_drive_ctrl_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
      end \
   end
module dsc_drive_ctrl_bench
   import dsc_pkg::*;
;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam int HSC = 8; // shortened homing step interval
   localparam int LIMIT = 20000; // hang guard in cycles
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout, hresp;
   logic [31:0] hrdata, rd;
   dsc_host_s host;
   dsc_mech_s mech = '0;
   dsc_strap_s straps = dsc_strap_s'(STRAP_SHIPPED);
   logic spindle_run, lamp_on, sl_out, sl_oe, head_step, step_in_dir;
   logic ready, media_swapped_flag, standby;
   logic [1:0] h_unit = 2'h1;
   logic h_sel = 1'b0, h_motor = 1'b0, h_busy = 1'b0;
   logic h_go = 1'b0, h_dir = 1'b0, idx_run = 1'b0;
   int cyc = 0, n_steps = 0, n_out = 0, last_step = 0;
   int n_mismatch = 0, tests_run = 0, t0, n0, th, i0;
   logic run_exp;

   always #10 hclk = ~hclk; // 50 MHz

   // ---------------------------------------------------------------
   // design and host
   // ---------------------------------------------------------------
   dsc_drive_ctrl #(.MOTOR_WAIT_CYC(20), .CHUCK_CYC(30),
      .HOME_STEP_CYC(HSC), .SETTLE_CYC(10)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .host_in(host), .mech_in(mech), .strap_in(straps),
      .spindle_run(spindle_run), .lamp_on(lamp_on),
      .shared_line_out(sl_out), .shared_line_oe(sl_oe),
      .head_step(head_step), .head_step_inward(step_in_dir),
      .ready(ready), .media_swapped_flag(media_swapped_flag),
      .standby(standby));

   dsc_host_model HOST (.hclk(hclk), .unit_idx(h_unit), .sel_en(h_sel),
      .motor_on(h_motor), .in_use(h_busy), .step_go(h_go),
      .step_in(h_dir), .host_out(host));

   // ---------------------------------------------------------------
   // cycle count, index wheel, step counting and hang guard
   // ---------------------------------------------------------------
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      mech.index_sense <= idx_run && (cyc % 10 < 3);
      if (head_step === 1'b1) begin
         n_steps <= n_steps + 1;
         if (step_in_dir === 1'b0) n_out <= n_out + 1;
         last_step <= cyc;
      end
      if (cyc == LIMIT) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic settle(); // pin to output takes about 5 edges
      repeat (8) @(posedge hclk);
   endtask

   // one single word transfer; waits on hready, no fixed latency
   task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask

   task automatic do_reset(input logic home);
      @(posedge hclk);
      straps.auto_home_strap <= home;
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
   endtask

   task automatic do_step(); // one host step, spacing kept by the model
      @(posedge hclk);
      t0 = cyc;
      h_go <= 1'b1;
      @(posedge hclk);
      h_go <= 1'b0;
      repeat (14) @(posedge hclk);
   endtask

   task tally_and_finish();
      $display("comparisons=%0d mismatches=%0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(75280));
      do_reset(1'b0);
      repeat (100) @(posedge hclk);
      `CHK(n_steps, 0)
      `CHK(head_step, 1'b0)
      `CHK(media_swapped_flag, 1'b1)
      `CHK(standby, 1'b1)
      ahb(1'b0, STRAPS_OFS, 32'h0, rd);
      `CHK(rd[10:0], STRAP_SHIPPED)
      `CHK(hresp, 1'b0)
      ahb(1'b1, 8'h0C, 32'hFFFF_FFFF, rd);
      ahb(1'b0, 8'h0C, 32'h0, rd);
      `CHK(rd, RD_ZERO)
      // every address against every select line, lamp mode 0
      h_sel <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         straps.unit_address_straps <= 4'h1 << a;
         for (int u = 0; u < 4; u++) begin
            h_unit <= 2'(u);
            settle();
            ahb(1'b0, STATUS_OFS, 32'h0, rd);
            `CHK(rd[1], 1'(u == a))
            `CHK(lamp_on, 1'(u == a))
         end
      end
      h_sel <= 1'b0;
      h_busy <= 1'b1;
      straps.unit_address_straps <= 4'h2; // one address per drive
      h_unit <= 2'h1;
      settle();
      `CHK(lamp_on, 1'b1)
      // no disk: nothing may spin
      repeat (8) begin
         {h_motor, h_sel, straps.motor_follows_select_strap} <= 3'($urandom);
         settle();
         `CHK(spindle_run, 1'b0)
      end
      {h_motor, h_sel, h_busy} <= 3'h0;
      straps.lamp_mode_bit1 <= 1'b1;
      mech.disk_present <= 1'b1;
      settle();
      `CHK(spindle_run, 1'b1)
      `CHK(lamp_on, 1'b1)
      repeat (40) @(posedge hclk);
      // random run and lamp conditions, lamp modes 1 and 2
      repeat (16) begin
         {h_motor, h_sel, h_busy} <= 3'($urandom);
         straps.motor_follows_select_strap <= 1'($urandom);
         straps.lamp_mode_bit0 <= 1'($urandom);
         @(posedge hclk);
         straps.lamp_mode_bit1 <= ~straps.lamp_mode_bit0;
         settle();
         run_exp = h_motor | (straps.motor_follows_select_strap & h_sel);
         `CHK(spindle_run, run_exp)
         `CHK(lamp_on, straps.lamp_mode_bit0 ? h_busy : run_exp | h_busy)
      end
      // step with the spindle stopped, from stand-by
      {h_motor, h_busy, h_dir} <= 3'h0;
      h_sel <= 1'b1;
      straps.motor_follows_select_strap <= 1'b0;
      repeat (20) @(posedge hclk);
      `CHK(standby, 1'b1)
      `CHK(sl_oe, 1'b1)
      `CHK(sl_out, 1'b1)
      n0 = n_steps;
      do_step();
      `CHK(n_steps - n0, 1)
      `CHK(last_step - t0 <= 8, 1'b1)
      `CHK(media_swapped_flag, 1'b0)
      `CHK(sl_out, 1'b0)
      repeat (30) @(posedge hclk);
      `CHK(standby, 1'b1)
      // ready path: never both output straps at once
      straps.pin_out_change_strap <= 1'b0;
      straps.ready_out_strap <= 1'b1;
      {straps.lamp_mode_bit0, straps.lamp_mode_bit1} <= 2'h3;
      {mech.speed_ok, idx_run, h_motor} <= 3'h7;
      settle();
      `CHK(ready, 1'b0)
      repeat (60) @(posedge hclk);
      `CHK(ready, 1'b1)
      `CHK(sl_out, 1'b1)
      `CHK(lamp_on, 1'b1)
      h_sel <= 1'b0;
      settle();
      `CHK(lamp_on, 1'b0)
      // power-on homing from a far track, host steps refused meanwhile
      do_reset(1'b1);
      th = cyc;
      n0 = n_out;
      i0 = n_steps - n_out;
      h_dir <= 1'b1;
      repeat (100) @(posedge hclk);
      do_step();
      `CHK(ready, 1'b0)
      repeat (85 * HSC) @(posedge hclk);
      `CHK(n_out - n0, 85)
      `CHK(n_steps - n_out - i0, 0)
      `CHK(last_step - th <= 85 * HSC + 30, 1'b1)
      repeat (60) @(posedge hclk);
      `CHK(ready, 1'b1)
      h_motor <= 1'b0;
      settle();
      `CHK(ready, 1'b0)
      mech.disk_present <= 1'b0;
      h_motor <= 1'b1;
      settle();
      `CHK(media_swapped_flag, 1'b1)
      `CHK(spindle_run, 1'b0)
      straps.ready_out_strap <= 1'b0;
      settle();
      `CHK(sl_oe, 1'b0)
      // re-home from the control word, ended by the outer-track sensor
      n0 = n_out;
      ahb(1'b1, CTRL_OFS, 32'h0000_0001, rd);
      repeat (4 * HSC) @(posedge hclk);
      `CHK(n_out - n0 >= 2, 1'b1)
      mech.track0_sense <= 1'b1;
      repeat (2 * HSC) @(posedge hclk);
      n0 = n_out;
      ahb(1'b0, STATUS_OFS, 32'h0, rd);
      `CHK(rd[4], 1'b0)
      repeat (2 * HSC) @(posedge hclk);
      `CHK(n_out - n0, 0)
      tally_and_finish();
   end
endmodule
`default_nettype wire
